/* File: boot_cmd_pkg.sv */
package boot_cmd_pkg;
   // Host bus widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Boot window ranges
   localparam logic [15:0] BOOT_LO_BASE = 16'h0000;
   localparam logic [15:0] BOOT_LO_LAST = 16'h01ff;
   localparam logic [15:0] BOOT_HI_BASE = 16'h8000;
   localparam logic [15:0] BOOT_HI_LAST = 16'h800f;

   // Register offsets
   localparam logic [15:0] OFF_START_BLOCK = 16'hf24c;
   localparam logic [15:0] OFF_END_BLOCK   = 16'hf24d;
   localparam logic [15:0] OFF_PROT_STATE  = 16'hf24e;
   localparam logic [15:0] OFF_ECC_SUMMARY = 16'hff00;
   localparam logic [15:0] OFF_S0_MAIN_POS = 16'hff01;
   localparam logic [15:0] OFF_S0_SPAR_POS = 16'hff02;
   localparam logic [15:0] OFF_S1_MAIN_POS = 16'hff03;
   localparam logic [15:0] OFF_S1_SPAR_POS = 16'hff04;
   localparam logic [15:0] OFF_INT_STATUS  = 16'hf241;
   localparam logic [15:0] OFF_BLOCK_SEL   = 16'hf100;
   localparam logic [15:0] OFF_PAGE_SEL    = 16'hf107;

   // Identification read offsets
   localparam logic [15:0] ID_MAKER_OFF  = 16'h0000;
   localparam logic [15:0] ID_DEVICE_OFF = 16'h0001;
   localparam logic [15:0] ID_PROT_OFF   = 16'h0002;

   // Command words
   localparam logic [15:0] CMD_RESET     = 16'h00f0;
   localparam logic [15:0] CMD_LOAD      = 16'h00e0;
   localparam logic [15:0] CMD_LOAD_GO   = 16'h0000;
   localparam logic [15:0] CMD_IDENTIFY  = 16'h0090;

   // Field layout
   localparam int unsigned BLOCK_W     = 9;
   localparam int unsigned PAGE_W      = 6;
   localparam int unsigned PAGE_POS    = 2;
   localparam int unsigned INT_MASTER  = 15;
   localparam int unsigned INT_LOAD    = 7;
   localparam int unsigned SPARE_LOC   = 4;

   // Reset values
   localparam logic [15:0] PROT_RESET  = 16'h0002;
   localparam logic [15:0] ZERO_RESET  = 16'h0000;

   // Buffer geometry: 1 KB page as 512 words
   localparam int unsigned BUF_AW      = 9;
   localparam int unsigned BUF_DEPTH   = 512;
   localparam logic [15:0] DATA_BUF_BASE = 16'h0200;

   // Load engine: fake copy time, one word per cycle
   localparam logic [9:0] LOAD_WORDS   = 10'd512;

   // Fault code values
   localparam logic [1:0] FAULT_NONE   = 2'b00;
   localparam logic [1:0] FAULT_SINGLE = 2'b01;
   localparam logic [1:0] FAULT_DOUBLE = 2'b10;

   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_LOAD1 = 2'b01,
      ST_BUSY  = 2'b11,
      ST_IDENT = 2'b10
   } cmd_state_t;
endpackage

/* File: buf_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module buf_ram
   import boot_cmd_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_we,
   input  wire logic [BUF_AW-1:0] i_waddr,
   input  wire logic [15:0]       i_wdata,
   input  wire logic [BUF_AW-1:0] i_raddr,
   output logic      [15:0]       o_rdata
);
   logic [15:0] mem [BUF_DEPTH];

   // Storage has no reset; contents survive command reset
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule
`default_nettype wire

/* File: ecc_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module ecc_capture
   import boot_cmd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_clear,
   input  wire logic        i_capture,
   input  wire logic [1:0]  i_main_code [2],
   input  wire logic [1:0]  i_spare_code [2],
   input  wire logic [7:0]  i_main_word [2],
   input  wire logic [3:0]  i_main_line [2],
   input  wire logic [1:0]  i_spare_loc [2],
   input  wire logic [3:0]  i_spare_line [2],
   output logic      [15:0] o_summary,
   output logic      [15:0] o_main_pos [2],
   output logic      [15:0] o_spare_pos [2]
);
   typedef struct packed {
      logic [15:0]      summary;
      logic [1:0][15:0] main_pos;
      logic [1:0][15:0] spare_pos;
   } ecc_state_t;

   ecc_state_t st_q;
   ecc_state_t st_d;

   // Latch results per sector; host writes never reach here
   always_comb begin
      st_d = st_q;
      // Capture wins over a clear in the same cycle
      if (i_capture) begin
         st_d.summary = ZERO_RESET;
         for (int s = 0; s < 2; s++) begin
            st_d.summary[4*s +: 2]     = i_main_code[s];
            st_d.summary[4*s + 2 +: 2] = i_spare_code[s];
            st_d.main_pos[s]  = {4'h0, i_main_word[s], i_main_line[s]};
            st_d.spare_pos[s] = {10'h000, i_spare_loc[s], i_spare_line[s]};
         end
      end else if (i_clear) begin
         st_d = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_summary = st_q.summary;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_out
         assign o_main_pos[g]  = st_q.main_pos[g];
         assign o_spare_pos[g] = st_q.spare_pos[g];
      end
   endgenerate
endmodule
`default_nettype wire

/* File: boot_area_command_and_status.sv */
// Behaviour
// - Lock range end block is 9 bits, upper bits read zero.
// - Protection state shows unlocked, locked, tight flags; resets to locked.
// - Each checked sector gets a two-bit fault code after load.
// - Four codes for main and spare of two sectors, reset zero.
// - Main fault records failing word of 256 and data line.
// - Spare fault puts word locator in bits 5:4 plus line.
// - Fault positions also update during boot copy.
// - Commands accepted only at boot window addresses.
// - Boot window reads return boot data unless a command is pending.
// - Writes outside boot window are plain buffer or register writes.
// - Command runs after last cycle; bad cycle returns to ready.
// - Writing 00F0h in boot window resets internal state.
// - Write 00E0h then 0000h loads one page to first buffer.
// - Page selector increments after load, wrapping inside its block.
// - Block and page selectors default to zero.
// - 0090h then read offsets 0,1,2 for maker, device, protection.
// - Any write except 0090h in the boot window ends identification mode.
// - Single-cycle buffer window access reads directly while no command is pending; writes land whenever no load is running.
// - Start block register pairs with end block for lock commands.
// - Load done sets load and master flags until host writes zero.
`timescale 1ns/1ps
`default_nettype none
module boot_area_command_and_status
   import boot_cmd_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE  = 16'h0a5a,  // Arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0123   // Arbitrary value
) (
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   input  wire logic               i_wr,           // One-cycle write strobe
   input  wire logic               i_rd,           // One-cycle read strobe
   input  wire logic [ADDR_W-1:0]  i_addr,
   input  wire logic [DATA_W-1:0]  i_wdata,
   input  wire logic               i_boot_copy_done, // Power-up copy finished
   input  wire logic [2:0]         i_prot_flags,   // Core: unlocked, locked, tight
   input  wire logic               i_prot_valid,
   input  wire logic [1:0]         i_main_code [2],
   input  wire logic [1:0]         i_spare_code [2],
   input  wire logic [7:0]         i_main_word [2],
   input  wire logic [3:0]         i_main_line [2],
   input  wire logic [1:0]         i_spare_loc [2],
   input  wire logic [3:0]         i_spare_line [2],
   output logic      [DATA_W-1:0]  o_rdata,
   output logic                    o_rvalid,
   output logic                    o_busy,
   output logic                    o_load_req,     // Pulse: core page fetch
   output logic      [BLOCK_W-1:0] o_load_block,
   output logic      [PAGE_W-1:0]  o_load_page,
   output logic      [BLOCK_W-1:0] o_range_start_block,
   output logic      [BLOCK_W-1:0] o_range_end_block,
   output logic                    o_int
);
   typedef struct packed {
      cmd_state_t         fsm;
      logic [9:0]         load_cnt;
      logic [BLOCK_W-1:0] start_blk;
      logic [BLOCK_W-1:0] end_blk;
      logic [2:0]         prot;
      logic [BLOCK_W-1:0] blk_sel;
      logic [PAGE_W-1:0]  page_sel;
      logic               load_done_flag;
      logic               master_flag;
      logic               load_req;
      logic               capture;
      logic               soft_rst;
      logic               rvalid;
      logic [15:0]        rdata;
      logic               rd_from_ram;
      logic               rd_boot;
      logic               rd_outv;
      logic [15:0]        rd_out;
      logic               busy;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;

   logic              in_boot;
   logic              in_data;
   logic [15:0]       ram_rdata;
   logic              ram_we;
   logic [BUF_AW-1:0] ram_waddr;
   logic [BUF_AW-1:0] ram_raddr;
   logic [15:0]       boot_rdata;
   logic [15:0]       ecc_summary;
   logic [15:0]       ecc_main [2];
   logic [15:0]       ecc_spare [2];
   logic              loading;
   logic              load_fin;

   assign in_boot = (i_addr <= BOOT_LO_LAST) ||
                    ((i_addr >= BOOT_HI_BASE) && (i_addr <= BOOT_HI_LAST));
   assign in_data = !in_boot && (i_addr < OFF_BLOCK_SEL);
   assign loading = (st_q.fsm == ST_BUSY);
   assign load_fin = loading && (st_q.load_cnt == LOAD_WORDS - 10'd1);

   // Load engine fills the first data buffer; host writes land otherwise
   always_comb begin
      ram_we    = 1'b0;
      ram_waddr = i_addr[BUF_AW-1:0];
      ram_raddr = i_addr[BUF_AW-1:0];
      if (loading) begin
         ram_we    = 1'b1;
         ram_waddr = st_q.load_cnt[BUF_AW-1:0];
      end else if (i_wr && in_data) begin
         ram_we = 1'b1;
      end
   end

   // Loaded data stands in for core page data
   buf_ram u_data_buf (
      .i_clk   (i_clk),
      .i_we    (ram_we),
      .i_waddr (ram_waddr),
      .i_wdata (loading ? {st_q.page_sel, st_q.load_cnt} : i_wdata),
      .i_raddr (ram_raddr),
      .o_rdata (ram_rdata)
   );

   // Boot copy is preloaded by the power-up path
   buf_ram u_boot_buf (
      .i_clk   (i_clk),
      .i_we    (1'b0),
      .i_waddr ('0),
      .i_wdata ('0),
      .i_raddr (i_addr[BUF_AW-1:0]),
      .o_rdata (boot_rdata)
   );

   ecc_capture u_ecc (
      .i_clk        (i_clk),
      .i_rst_b      (i_rst_b),
      .i_clear      (st_q.soft_rst),
      .i_capture    (st_q.capture || i_boot_copy_done),
      .i_main_code  (i_main_code),
      .i_spare_code (i_spare_code),
      .i_main_word  (i_main_word),
      .i_main_line  (i_main_line),
      .i_spare_loc  (i_spare_loc),
      .i_spare_line (i_spare_line),
      .o_summary    (ecc_summary),
      .o_main_pos   (ecc_main),
      .o_spare_pos  (ecc_spare)
   );

   // Command decode, register writes and read mux
   always_comb begin
      st_d          = st_q;
      st_d.load_req = 1'b0;
      st_d.capture  = 1'b0;
      st_d.soft_rst = 1'b0;
      st_d.rvalid   = 1'b0;
      st_d.rd_from_ram = 1'b0;
      if (i_prot_valid) begin
         st_d.prot = i_prot_flags;
      end
      // Load engine steps one word per cycle
      if (loading) begin
         st_d.load_cnt = st_q.load_cnt + 10'd1;
         if (load_fin) begin
            st_d.fsm = ST_READY;
            st_d.capture = 1'b1;
            st_d.page_sel = st_q.page_sel + 6'd1;
            st_d.load_done_flag = 1'b1;
            st_d.master_flag = 1'b1;
         end
      end
      if (i_wr && !loading) begin
         if (in_boot) begin
            case (st_q.fsm)
               ST_LOAD1: begin
                  if (i_wdata == CMD_LOAD_GO) begin
                     st_d.fsm = ST_BUSY;
                     st_d.load_cnt = '0;
                     st_d.load_req = 1'b1;
                  end else begin
                     st_d.fsm = ST_READY;
                  end
               end
               default: begin
                  st_d.fsm = ST_READY;
                  if (i_wdata == CMD_LOAD) begin
                     st_d.fsm = ST_LOAD1;
                  end else if (i_wdata == CMD_IDENTIFY) begin
                     st_d.fsm = ST_IDENT;
                  end else if (i_wdata == CMD_RESET) begin
                     st_d = '0;
                     st_d.prot = PROT_RESET[2:0];
                     st_d.soft_rst = 1'b1;
                  end
               end
            endcase
         end else begin
            st_d.fsm = ST_READY;
            case (i_addr)
               OFF_START_BLOCK: st_d.start_blk = i_wdata[BLOCK_W-1:0];
               OFF_END_BLOCK:   st_d.end_blk = i_wdata[BLOCK_W-1:0];
               OFF_BLOCK_SEL:   st_d.blk_sel = i_wdata[BLOCK_W-1:0];
               OFF_PAGE_SEL:    st_d.page_sel = i_wdata[PAGE_POS +: PAGE_W];
               OFF_INT_STATUS: begin
                  // cleared by writing zero, set wins
                  if (!i_wdata[INT_MASTER] && !(load_fin || i_boot_copy_done)) begin
                     st_d.master_flag = 1'b0;
                  end
                  if (!i_wdata[INT_LOAD] && !(load_fin || i_boot_copy_done)) begin
                     st_d.load_done_flag = 1'b0;
                  end
               end
               default: st_d.fsm = ST_READY;
            endcase
         end
      end
      // Boot copy sets after any soft reset, so the set wins
      if (i_boot_copy_done) begin
         st_d.load_done_flag = 1'b1;
         st_d.master_flag = 1'b1;
      end
      if (i_rd) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = ZERO_RESET;
         if (in_boot && st_q.fsm == ST_IDENT) begin
            case (i_addr)
               ID_MAKER_OFF:  st_d.rdata = MAKER_CODE;
               ID_DEVICE_OFF: st_d.rdata = DEVICE_CODE;
               ID_PROT_OFF:   st_d.rdata = {13'h0000, st_q.prot};
               default:       st_d.rdata = ZERO_RESET;
            endcase
         end else if (in_boot || in_data) begin
            // boot data only with no command pending
            st_d.rd_from_ram = (st_q.fsm == ST_READY);
         end else begin
            case (i_addr)
               OFF_START_BLOCK: st_d.rdata = {7'h00, st_q.start_blk};
               OFF_END_BLOCK:   st_d.rdata = {7'h00, st_q.end_blk};
               OFF_PROT_STATE:  st_d.rdata = {13'h0000, st_q.prot};
               OFF_ECC_SUMMARY: st_d.rdata = ecc_summary;
               OFF_S0_MAIN_POS: st_d.rdata = ecc_main[0];
               OFF_S0_SPAR_POS: st_d.rdata = ecc_spare[0];
               OFF_S1_MAIN_POS: st_d.rdata = ecc_main[1];
               OFF_S1_SPAR_POS: st_d.rdata = ecc_spare[1];
               OFF_BLOCK_SEL:   st_d.rdata = {7'h00, st_q.blk_sel};
               OFF_PAGE_SEL:    st_d.rdata = {8'h00, st_q.page_sel, 2'b00};
               OFF_INT_STATUS:  st_d.rdata = {st_q.master_flag, 7'h00,
                                               st_q.load_done_flag, 7'h00};
               default:         st_d.rdata = ZERO_RESET;
            endcase
         end
      end
      // Output stage; buffer data lands one cycle after the strobe
      st_d.rd_boot = in_boot;
      st_d.rd_outv = st_q.rvalid;
      st_d.rd_out  = st_q.rdata;
      // stored boot data only from the ready state
      if (st_q.rd_from_ram) begin
         st_d.rd_out = st_q.rd_boot ? boot_rdata : ram_rdata;
      end
      // Busy kept in its own flop so the pin is registered
      st_d.busy = (st_d.fsm == ST_BUSY);
   end

   // Registers; selectors reset to zero
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q      <= '0;
         st_q.prot <= PROT_RESET[2:0];
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rdata             = st_q.rd_out;
   assign o_rvalid            = st_q.rd_outv;
   assign o_busy              = st_q.busy;
   assign o_load_req          = st_q.load_req;
   assign o_load_block        = st_q.blk_sel;
   assign o_load_page         = st_q.page_sel;
   assign o_range_start_block = st_q.start_blk;
   assign o_range_end_block   = st_q.end_blk;
   assign o_int               = st_q.master_flag;
endmodule
`default_nettype wire

/* File: boot_cmd_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_properties
   import boot_cmd_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst_b,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_boot_copy_done,
   input wire logic              o_rvalid,
   input wire logic              o_busy,
   input wire logic              o_load_req,
   input wire logic [8:0]        o_load_block,
   input wire logic [5:0]        o_load_page,
   input wire logic [8:0]        o_range_end_block,
   input wire logic              o_int
);
   logic        in_boot;
   logic [8:0]  wdata_low;
   logic [10:0] busy_cnt_q;
   logic [5:0]  page_at_req_q;

   // Command window decode, both address ranges
   assign in_boot = (i_addr <= BOOT_LO_LAST) || (i_addr >= BOOT_HI_BASE && i_addr <= BOOT_HI_LAST);
   assign wdata_low = i_wdata[8:0];

   // Busy span length and the page a fetch started from
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_cnt_q <= 11'h000;
         page_at_req_q <= 6'h00;
      end else begin
         busy_cnt_q <= o_busy ? busy_cnt_q + 11'h001 : 11'h000;
         if (o_load_req) begin
            page_at_req_q <= o_load_page;
         end
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   // Bench leaves one idle cycle between the two command words
   sequence s_load;
      (i_wr && in_boot && i_wdata == CMD_LOAD && !o_busy) ##1 !i_wr
      ##1 (i_wr && in_boot && i_wdata == CMD_LOAD_GO);
   endsequence

   a_load_start: assert property (s_load |=> o_load_req)
      else $error("load command did not start a fetch");
   a_req_busy: assert property (o_load_req |-> o_busy)
      else $error("fetch request without busy");
   a_single_req: assert property (o_busy && $past(o_busy) |-> !o_load_req)
      else $error("second fetch while busy");
   a_busy_len: assert property ($fell(o_busy) |-> busy_cnt_q == 11'd512)
      else $error("busy span is not one page");
   a_page_step: assert property ($fell(o_busy) |-> ##[0:1] (o_load_page == page_at_req_q + 6'h01))
      else $error("page selector did not step by one");
   a_int_set: assert property ($fell(o_busy) |-> ##[0:1] o_int)
      else $error("load done flag not raised");
   a_read_answer: assert property (i_rd |-> ##2 o_rvalid)
      else $error("read not answered in two cycles");
   a_outside_write: assert property (i_wr && !in_boot |=> !o_load_req)
      else $error("write outside window started a fetch");
   a_end_write: assert property (i_wr && i_addr == OFF_END_BLOCK && !o_busy
                                 |=> o_range_end_block == $past(wdata_low))
      else $error("end block field not written");
   a_boot_copy: assert property (i_boot_copy_done |=> o_int)
      else $error("boot copy did not raise flag");
   a_reset_cmd: assert property (i_wr && in_boot && i_wdata == CMD_RESET && !o_busy
                                 && !i_boot_copy_done |=> o_load_page == 6'h00
                                 && o_load_block == 9'h000 && o_range_end_block == 9'h000
                                 && !o_int)
      else $error("reset command left state behind");

   c_load: cover property (s_load);
   c_done: cover property ($fell(o_busy));
   c_copy: cover property (i_boot_copy_done);
endmodule

bind boot_area_command_and_status boot_cmd_properties u_props (
   .i_clk, .i_rst_b, .i_wr, .i_rd, .i_addr, .i_wdata, .i_boot_copy_done, .o_rvalid,
   .o_busy, .o_load_req, .o_load_block, .o_load_page, .o_range_end_block, .o_int
);
`default_nettype wire

/* File: flash_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_core_model
   import boot_cmd_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_load_req,
   output logic      [2:0] o_prot_flags,
   output logic            o_prot_valid,
   output logic      [1:0] o_main_code [2],
   output logic      [1:0] o_spare_code [2],
   output logic      [7:0] o_main_word [2],
   output logic      [3:0] o_main_line [2],
   output logic      [1:0] o_spare_loc [2],
   output logic      [3:0] o_spare_line [2]
);
   // legal codes only, never the reserved 11
   assign o_main_code = '{FAULT_SINGLE, FAULT_DOUBLE};
   assign o_spare_code = '{FAULT_NONE, FAULT_SINGLE};
   // word and line, last and first word of the sector
   assign o_main_word = '{8'hff, 8'h00};
   assign o_main_line = '{4'hf, 4'h3};
   // spare locator, second and first spare word
   assign o_spare_loc = '{2'b01, 2'b00};
   assign o_spare_line = '{4'h9, 4'h5};
   // block unlocked once a fetch selects it
   assign o_prot_flags = 3'b100;

   // Status arrives a cycle after the fetch request, mid-busy
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prot_valid <= 1'b0;
      end else begin
         o_prot_valid <= i_load_req;
      end
   end
endmodule
`default_nettype wire

/* File: test_boot_area_command_and_status.sv */
`timescale 1ns/1ps
`default_nettype none
module test_boot_area_command_and_status
   import boot_cmd_pkg::*;
;
   localparam logic [15:0] MAKER = 16'h1357;  // Arbitrary value
   localparam logic [15:0] DEVICE = 16'h0246; // Arbitrary value
   logic        i_clk, i_rst_b, i_wr, i_rd, i_boot_copy_done, i_prot_valid;
   logic        o_rvalid, o_busy, o_load_req, o_int;
   logic [15:0] i_addr, i_wdata, o_rdata, last_data;
   logic [2:0]  i_prot_flags;
   logic [1:0]  i_main_code [2], i_spare_code [2], i_spare_loc [2];
   logic [7:0]  i_main_word [2];
   logic [3:0]  i_main_line [2], i_spare_line [2];
   logic [8:0]  o_load_block, o_range_start_block, o_range_end_block;
   logic [5:0]  o_load_page;
   int          err_count;
   int          comparisons;

   boot_area_command_and_status #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) uut (
      .i_clk, .i_rst_b, .i_wr, .i_rd, .i_addr, .i_wdata, .i_boot_copy_done,
      .i_prot_flags, .i_prot_valid, .i_main_code, .i_spare_code, .i_main_word,
      .i_main_line, .i_spare_loc, .i_spare_line, .o_rdata, .o_rvalid, .o_busy,
      .o_load_req, .o_load_block, .o_load_page, .o_range_start_block,
      .o_range_end_block, .o_int);
   flash_core_model core (
      .i_clk, .i_rst_b, .i_load_req(o_load_req), .o_prot_flags(i_prot_flags),
      .o_prot_valid(i_prot_valid), .o_main_code(i_main_code),
      .o_spare_code(i_spare_code), .o_main_word(i_main_word),
      .o_main_line(i_main_line), .o_spare_loc(i_spare_loc), .o_spare_line(i_spare_line));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic finish_test();
      $display("Counts: %0d errors, %0d comparisons", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Strobes are held one full cycle, then dropped a cycle later
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(posedge i_clk);
      #1;
      i_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a);
      @(posedge i_clk);
      #1;
      i_rd = 1'b1;
      i_addr = a;
      @(posedge i_clk);
      #1;
      i_rd = 1'b0;
      @(posedge i_clk);
      #1;
      chk({15'h0, o_rvalid}, 16'h0001);
      last_data = o_rdata;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      rd(a);
      chk(last_data, exp);
   endtask

   // Fetch one page; a register write during busy must be dropped
   task automatic ld(input logic [8:0] blk, input logic [5:0] pg);
      logic [5:0] nxt;
      int         n;
      nxt = pg + 6'h01;
      wr(16'h8000, CMD_LOAD);
      wr(16'h01ff, CMD_LOAD_GO);
      chk({15'h0, o_load_req}, 16'h0001);
      chk({1'b0, o_load_block, o_load_page}, {1'b0, blk, pg});
      wr(OFF_END_BLOCK, 16'h0055);
      for (n = 0; n < 600 && o_busy === 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      @(posedge i_clk);
      #1;
      chk({1'b0, o_load_block, o_load_page}, {1'b0, blk, nxt});
      chk({15'h0, o_int}, 16'h0001);
   endtask

   task automatic t_defaults();
      rdc(OFF_PROT_STATE, PROT_RESET);
      rdc(OFF_ECC_SUMMARY, ZERO_RESET);
      rdc(OFF_S1_SPAR_POS, ZERO_RESET);
      rdc(OFF_END_BLOCK, ZERO_RESET);
      chk({1'b0, o_load_block, o_load_page}, 16'h0000);
   endtask

   task automatic t_buffer();
      wr(16'h0200, 16'hbeef);
      wr(16'hf0ff, 16'h1234);
      rdc(16'h0200, 16'hbeef);
      rdc(16'hf0ff, 16'h1234);
   endtask

   task automatic t_registers();
      // end block set at or above start block
      wr(OFF_END_BLOCK, 16'hffff);
      rdc(OFF_END_BLOCK, 16'h01ff);
      wr(OFF_START_BLOCK, 16'h0155);
      rdc(OFF_START_BLOCK, 16'h0155);
      chk({7'h0, o_range_start_block}, 16'h0155);
      wr(OFF_PROT_STATE, 16'hffff);
      rdc(OFF_PROT_STATE, PROT_RESET);
      wr(OFF_S0_MAIN_POS, 16'hffff);
      rdc(OFF_S0_MAIN_POS, ZERO_RESET);
   endtask

   task automatic t_identify();
      wr(16'h0100, CMD_IDENTIFY);
      rdc(ID_MAKER_OFF, MAKER);
      rdc(ID_DEVICE_OFF, DEVICE);
      rdc(ID_PROT_OFF, PROT_RESET);
      wr(OFF_END_BLOCK, 16'h0007);
      rd(ID_MAKER_OFF);
      chk({15'h0, last_data !== MAKER}, 16'h0001);
   endtask

   task automatic t_abort();
      wr(16'h8000, CMD_LOAD);
      rdc(16'h8000, ZERO_RESET);
      wr(16'h8001, 16'h1234);
      wr(16'h8002, CMD_LOAD_GO);
      chk({15'h0, o_busy}, 16'h0000);
      wr(16'h0200, CMD_LOAD);
      wr(16'h0000, CMD_LOAD_GO);
      chk({15'h0, o_busy}, 16'h0000);
      wr(16'h800f, CMD_LOAD);
      wr(16'h0200, CMD_LOAD_GO);
      chk({15'h0, o_busy}, 16'h0000);
      rdc(16'h0200, CMD_LOAD_GO);
   endtask

   task automatic t_load();
      ld(9'h000, 6'h00);
      rdc(OFF_PAGE_SEL, 16'h0004);
      rdc(OFF_END_BLOCK, 16'h0007);
      rdc(OFF_INT_STATUS, 16'h8080);
      rdc(OFF_ECC_SUMMARY, 16'h0061);
      rdc(OFF_S0_MAIN_POS, 16'h0fff);
      rdc(OFF_S0_SPAR_POS, 16'h0019);
      rdc(OFF_S1_MAIN_POS, 16'h0003);
      rdc(OFF_S1_SPAR_POS, 16'h0005);
      rdc(OFF_PROT_STATE, 16'h0004);
      wr(OFF_INT_STATUS, 16'h0000);
      rdc(OFF_INT_STATUS, 16'h0000);
   endtask

   task automatic t_wrap();
      wr(OFF_BLOCK_SEL, 16'h01ff);
      wr(OFF_PAGE_SEL, 16'h00fc);
      ld(9'h1ff, 6'h3f);
   endtask

   task automatic t_reset_cmd();
      wr(16'h800f, CMD_RESET);
      rdc(OFF_PAGE_SEL, ZERO_RESET);
      rdc(OFF_BLOCK_SEL, ZERO_RESET);
      rdc(OFF_END_BLOCK, ZERO_RESET);
      rdc(OFF_INT_STATUS, ZERO_RESET);
      rdc(OFF_ECC_SUMMARY, ZERO_RESET);
   endtask

   task automatic t_boot_copy();
      @(posedge i_clk);
      #1;
      i_boot_copy_done = 1'b1;
      @(posedge i_clk);
      #1;
      i_boot_copy_done = 1'b0;
      rdc(OFF_INT_STATUS, 16'h8080);
      rdc(OFF_S0_SPAR_POS, 16'h0019);
   endtask

   // Hang guard, well beyond two page fetches
   initial begin
      #100000;
      err_count++;
      finish_test();
   end

   initial begin
      i_rst_b = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      i_boot_copy_done = 1'b0;
      repeat (6) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      t_defaults();
      t_buffer();
      t_registers();
      t_identify();
      t_abort();
      t_load();
      t_wrap();
      t_reset_cmd();
      t_boot_copy();
      finish_test();
   end
endmodule
`default_nettype wire
